// ### core/irq_sources_time_base.sv
`timescale 1ns/100ps
`default_nettype none
module irq_sources_time_base
  import irq_pkg::*;
(
  input  wire logic                               clk_sys,
  input  wire logic                               reset,
  input  wire logic [ADDR_W-1:0]                  reg_addr,
  input  wire logic [DATA_W-1:0]                  reg_wdata,
  input  wire logic                               reg_write,
  input  wire logic                               reg_read,
  output var  logic [DATA_W-1:0]                  reg_rdata,
  input  wire logic                               conv_end,
  input  wire logic [NUM_TM-1:0]                  tm_match_a,
  input  wire logic [NUM_TM-1:0]                  tm_match_p,
  input  wire logic [SER_EVT_W-1:0]               serial_event,
  input  wire logic [NUM_UART-1:0][UART_EVT_W-1:0] uart_event,
  input  wire logic                               low_supply_detect,
  input  wire logic                               sub_clock,
  input  wire logic                               stack_full,
  input  wire logic                               irq_ack,
  input  wire logic                               return_from_interrupt,
  output var  logic                               irq_req,
  output var  logic [VEC_W-1:0]                   irq_vector,
  output var  logic                               wake
);

  logic [PSC_SRC_W-1:0] prescaler_source [NUM_TB];
  logic [NUM_TB-1:0]    timebase_run;
  logic [TB_PER_W-1:0]  timebase_period_sel [NUM_TB];
  logic                 global_irq_enable;
  logic [NUM_SRC-1:0]   src_en;
  logic [NUM_SRC-1:0]   src_flag;
  logic [NUM_GRP-1:0]   group_irq_enable;
  logic [NUM_GRP-1:0]   group_irq_flag;
  logic [TML_W-1:0]     tml_en;
  logic [TML_W-1:0]     tml_flag;
  logic [TML_W-1:0]     tml_act_prev;
  logic [NUM_SRC+NUM_GRP+TML_W-1:0] all_prev;
  logic [SEL_W-1:0]     irq_sel;
  logic [NUM_TB-1:0]    tb_ovf;

  // three-flop synchronisers for the sub clock and the detector
  logic [2:0] sub_sync;
  logic [2:0] lvd_sync;
  logic       sub_stable;
  logic       sub_prev;
  logic       lvd_stable;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sub_sync <= '0;
      lvd_sync <= '0;
    end else begin
      sub_sync <= {sub_sync[1:0], sub_clock};
      lvd_sync <= {lvd_sync[1:0], low_supply_detect};
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sub_stable <= 1'b0;
      lvd_stable <= 1'b0;
      sub_prev   <= 1'b0;
    end else begin
      if (sub_sync[1] == sub_sync[2]) begin
        sub_stable <= sub_sync[2];
      end
      if (lvd_sync[1] == lvd_sync[2]) begin
        lvd_stable <= lvd_sync[2];
      end
      sub_prev <= sub_stable;
    end
  end

  wire logic sub_rise = sub_stable & ~sub_prev;

  function automatic logic hit(input logic [ADDR_W-1:0] idx);
    hit = reg_write && (reg_addr == idx);
  endfunction

  // time bases: prescaler select and power-of-two divider
  genvar t;
  generate
    for (t = 0; t < NUM_TB; t++) begin : g_tb
      logic [1:0]       div4;
      logic [CNT_W-1:0] count;
      logic             tick;
      logic [CNT_W-1:0] last;

      always_comb begin
        if (prescaler_source[t][PSC_SUB_BIT]) begin
          tick = sub_rise;
        end else if (prescaler_source[t] == PSC_SYS_DIV4) begin
          tick = (div4 == DIV4_LAST);
        end else begin
          tick = 1'b1;
        end
      end

      // last count before wrap is two to the eight plus code, minus one
      assign last = CNT_W'((TB_BASE << timebase_period_sel[t]) - TB_ONE);
      assign tb_ovf[t] = timebase_run[t] && tick && (count == last);

      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          div4  <= '0;
          count <= '0;
        end else begin
          div4 <= div4 + 2'h1;
          if (!timebase_run[t]) begin
            count <= '0;
          end else if (tick) begin
            count <= tb_ovf[t] ? '0 : count + CNT_W'(1);
          end
        end
      end

      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          prescaler_source[t]    <= PSC_SYS;
          timebase_run[t]        <= 1'b0;
          timebase_period_sel[t] <= '0;
        end else begin
          if (hit(REG_PSC_A + ADDR_W'(t))) begin
            prescaler_source[t] <= reg_wdata[PSC_SRC_W-1:0];
          end
          if (hit(REG_TB_A + ADDR_W'(t))) begin
            timebase_run[t]        <= reg_wdata[TB_RUN_BIT];
            timebase_period_sel[t] <= reg_wdata[TB_PER_W-1:0];
          end
        end
      end
    end
  endgenerate

  // source events
  logic [NUM_SRC-1:0] src_set;
  logic [TML_W-1:0]   tml_set;
  genvar u;
  generate
    for (u = 0; u < NUM_UART; u++) begin : g_uart
      assign src_set[SRC_UART0+u] = |uart_event[u];
    end
    for (u = 0; u < NUM_TM; u++) begin : g_tm
      assign tml_set[2*u]   = tm_match_a[u];
      assign tml_set[2*u+1] = tm_match_p[u];
    end
  endgenerate
  assign src_set[SRC_CONV] = conv_end;
  assign src_set[SRC_TBA]  = tb_ovf[0];
  assign src_set[SRC_TBB]  = tb_ovf[1];
  assign src_set[SRC_SER]  = |serial_event;
  assign tml_set[LVD_BIT]  = lvd_stable;

  // candidate priority pick
  logic [NUM_CAND-1:0] cand;
  logic [SEL_W-1:0]    pick;
  logic                service;
  logic [NUM_CAND-1:0] svc_hot;
  assign cand    = {src_flag & src_en, group_irq_flag & group_irq_enable};
  assign service = irq_req && irq_ack;
  assign svc_hot = service ? (NUM_CAND'(1) << irq_sel) : '0;

  always_comb begin
    pick = '0;
    for (int i = NUM_CAND - 1; i >= 0; i--) begin
      if (cand[i]) begin
        pick = SEL_W'(i);
      end
    end
  end

  logic next_irq_req;
  assign next_irq_req = global_irq_enable && (|cand) && !stack_full && !service;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_req    <= 1'b0;
      irq_sel    <= '0;
      irq_vector <= '0;
    end else begin
      irq_req <= next_irq_req;
      if (next_irq_req) begin
        irq_sel    <= pick;
        irq_vector <= VEC_TABLE[pick];
      end
    end
  end

  // global enable
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      global_irq_enable <= 1'b0;
    end else if (service) begin
      global_irq_enable <= 1'b0;
    end else if (return_from_interrupt) begin
      global_irq_enable <= 1'b1;
    end else if (hit(REG_GLOBAL)) begin
      global_irq_enable <= reg_wdata[GLOBAL_BIT];
    end
  end

  // enables
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      src_en           <= '0;
      group_irq_enable <= '0;
      tml_en           <= '0;
    end else begin
      if (hit(REG_SRC_EN)) begin
        src_en <= reg_wdata[NUM_SRC-1:0];
      end
      if (hit(REG_GRP_EN)) begin
        group_irq_enable <= reg_wdata[NUM_GRP-1:0];
      end
      if (hit(REG_TML_EN)) begin
        tml_en <= reg_wdata[TML_W-1:0];
      end
    end
  end

  // direct source flags: write one to clear, service clears, set wins
  logic [NUM_SRC-1:0] src_wclr;
  assign src_wclr = (reg_write && reg_addr == REG_SRC_FLG) ? reg_wdata[NUM_SRC-1:0] : '0;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      src_flag <= '0;
    end else begin
      src_flag <= (src_flag & ~src_wclr & ~svc_hot[NUM_CAND-1:NUM_GRP]) | src_set;
    end
  end

  // timer and low supply flags: only software clears them
  logic [TML_W-1:0] tml_wclr;
  logic [TML_W-1:0] tml_act;
  logic [TML_W-1:0] tml_rise;
  assign tml_wclr = (reg_write && reg_addr == REG_TML_FLG) ? reg_wdata[TML_W-1:0] : '0;
  assign tml_act  = tml_flag & tml_en;
  assign tml_rise = tml_act & ~tml_act_prev;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tml_flag     <= '0;
      tml_act_prev <= '0;
    end else begin
      tml_flag     <= (tml_flag & ~tml_wclr) | tml_set;
      tml_act_prev <= tml_act;
    end
  end

  // group flags
  logic [NUM_GRP-1:0] grp_set;
  logic [NUM_GRP-1:0] grp_wclr;
  genvar g;
  generate
    for (g = 0; g < NUM_GRP; g++) begin : g_grp
      if (g == LVD_GRP) begin : g_lvd
        assign grp_set[g] = tml_rise[2*g] | tml_rise[2*g+1] | tml_rise[LVD_BIT];
      end else begin : g_plain
        assign grp_set[g] = tml_rise[2*g] | tml_rise[2*g+1];
      end
    end
  endgenerate
  assign grp_wclr = (reg_write && reg_addr == REG_GRP_FLG) ? reg_wdata[NUM_GRP-1:0] : '0;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      group_irq_flag <= '0;
    end else begin
      group_irq_flag <= (group_irq_flag & ~grp_wclr & ~svc_hot[NUM_GRP-1:0]) | grp_set;
    end
  end

  // wake on any rising flag
  logic [NUM_SRC+NUM_GRP+TML_W-1:0] all_flags;
  assign all_flags = {tml_flag, group_irq_flag, src_flag};

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      all_prev <= '0;
      wake     <= 1'b0;
    end else begin
      all_prev <= all_flags;
      wake     <= |(all_flags & ~all_prev);
    end
  end

  // read port
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = RD_NONE;
    unique case (reg_addr)
      REG_PSC_A:   rd_mux[PSC_SRC_W-1:0] = prescaler_source[0];
      REG_PSC_B:   rd_mux[PSC_SRC_W-1:0] = prescaler_source[1];
      REG_TB_A: begin
        rd_mux[TB_RUN_BIT]      = timebase_run[0];
        rd_mux[TB_PER_W-1:0]    = timebase_period_sel[0];
      end
      REG_TB_B: begin
        rd_mux[TB_RUN_BIT]      = timebase_run[1];
        rd_mux[TB_PER_W-1:0]    = timebase_period_sel[1];
      end
      REG_GLOBAL:  rd_mux[GLOBAL_BIT] = global_irq_enable;
      REG_SRC_EN:  rd_mux[NUM_SRC-1:0] = src_en;
      REG_SRC_FLG: rd_mux[NUM_SRC-1:0] = src_flag;
      REG_GRP_EN:  rd_mux[NUM_GRP-1:0] = group_irq_enable;
      REG_GRP_FLG: rd_mux[NUM_GRP-1:0] = group_irq_flag;
      REG_TML_EN:  rd_mux[TML_W-1:0] = tml_en;
      REG_TML_FLG: rd_mux[TML_W-1:0] = tml_flag;
      default:     rd_mux = RD_NONE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= RD_NONE;
    end else begin
      reg_rdata <= reg_read ? rd_mux : RD_NONE;
    end
  end

  // checks
  property p_conv_set;
    @(posedge clk_sys) disable iff (reset) conv_end |=> src_flag[SRC_CONV];
  endproperty
  a_conv_set: assert property (p_conv_set) else $error("conv flag not set");

  property p_req_needs_global;
    @(posedge clk_sys) disable iff (reset)
      !global_irq_enable ##1 !$past(service) |-> !irq_req;
  endproperty
  a_req_needs_global: assert property (p_req_needs_global) else $error("req without global");

  property p_stack_full;
    @(posedge clk_sys) disable iff (reset) stack_full |=> !irq_req;
  endproperty
  a_stack_full: assert property (p_stack_full) else $error("req with stack full");

  property p_service_global;
    @(posedge clk_sys) disable iff (reset) service |=> !global_irq_enable ##0 !irq_req;
  endproperty
  a_service_global: assert property (p_service_global) else $error("global not cleared");

  property p_conv_service;
    @(posedge clk_sys) disable iff (reset)
      service && irq_sel == SEL_W'(NUM_GRP + SRC_CONV) && !conv_end |=> !src_flag[SRC_CONV];
  endproperty
  a_conv_service: assert property (p_conv_service) else $error("conv flag kept");

  property p_tb_flag;
    @(posedge clk_sys) disable iff (reset) tb_ovf[0] |=> src_flag[SRC_TBA];
  endproperty
  a_tb_flag: assert property (p_tb_flag) else $error("time base flag not set");

  property p_tb_stopped;
    @(posedge clk_sys) disable iff (reset) !timebase_run[1] |=> !$rose(src_flag[SRC_TBB]);
  endproperty
  a_tb_stopped: assert property (p_tb_stopped) else $error("stopped time base overflowed");

  property p_group_keeps_tm;
    @(posedge clk_sys) disable iff (reset)
      service && irq_sel < SEL_W'(NUM_GRP) && !hit(REG_TML_FLG) |=> (tml_flag & $past(tml_flag)) == $past(tml_flag);
  endproperty
  a_group_keeps_tm: assert property (p_group_keeps_tm) else $error("timer flag cleared");

  property p_wake;
    @(posedge clk_sys) disable iff (reset) $rose(src_flag[SRC_SER]) |=> wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on rising flag");

  property p_return_from_interrupt;
    @(posedge clk_sys) disable iff (reset)
      return_from_interrupt && !service |=> global_irq_enable;
  endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return_from_interrupt left global clear");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (reset)
      reg_read && reg_addr == REG_TB_B |=> reg_rdata[TB_RUN_BIT-1:TB_PER_W] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

endmodule
`default_nettype wire

// ### core/irq_pkg.sv
// How it works
// - conversion end sets the converter-done flag
// - converter vectors only with global and own enable, stack not full
// - servicing converter clears its flag and the global enable
// - each time base sets its flag on divider overflow; vectors when enabled
// - servicing a time base clears its flag and the global enable
// - source select 00 system clock, 01 system clock over four, 1x sub clock
// - second time base period is two to the eight plus code prescaler clocks
// - unimplemented register bits read as zero
// - each timer module has compare-a and compare-p flags with enables
// - timer vectors need global, own and group enables, stack not full
// - timer service clears only group flag and global; software clears source
// - serial flag set on byte done, address match or bus timeout
// - serial service clears its flag and global; needs global and own enable
// - each uart flag is set by any of its six event pulses
// - uart service clears its flag and global; uart status left alone
// - low supply sets its flag; vectors through its group when enabled
// - low supply service clears only group flag and global enable
// - a group flag is set when any enabled member flag becomes set
// - any flag rising low to high raises wake, whatever the enables
// - return from interrupt sets the global enable again
package irq_pkg;
  localparam int ADDR_W     = 4;
  localparam int DATA_W     = 8;
  localparam int VEC_W      = 8;
  localparam int NUM_TB     = 2;
  localparam int NUM_TM     = 3;
  localparam int NUM_UART   = 2;
  localparam int NUM_GRP    = 3;
  localparam int UART_EVT_W = 6;
  localparam int SER_EVT_W  = 4;
  localparam int NUM_SRC    = 6;
  localparam int TML_W      = 2 * NUM_TM + 1;
  localparam int NUM_CAND   = NUM_GRP + NUM_SRC;
  localparam int SEL_W      = 4;
  localparam int CNT_W      = 15;

  // register indices
  localparam logic [ADDR_W-1:0] REG_PSC_A   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PSC_B   = 4'h1;
  localparam logic [ADDR_W-1:0] REG_TB_A    = 4'h2;
  localparam logic [ADDR_W-1:0] REG_TB_B    = 4'h3;
  localparam logic [ADDR_W-1:0] REG_GLOBAL  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SRC_EN  = 4'h5;
  localparam logic [ADDR_W-1:0] REG_SRC_FLG = 4'h6;
  localparam logic [ADDR_W-1:0] REG_GRP_EN  = 4'h7;
  localparam logic [ADDR_W-1:0] REG_GRP_FLG = 4'h8;
  localparam logic [ADDR_W-1:0] REG_TML_EN  = 4'h9;
  localparam logic [ADDR_W-1:0] REG_TML_FLG = 4'ha;

  // field positions
  localparam int TB_RUN_BIT = 7;
  localparam int TB_PER_W   = 3;
  localparam int PSC_SRC_W  = 2;
  localparam int PSC_SUB_BIT = 1;
  localparam int SRC_CONV  = 0;
  localparam int SRC_TBA   = 1;
  localparam int SRC_TBB   = 2;
  localparam int SRC_SER   = 3;
  localparam int SRC_UART0 = 4;
  localparam int LVD_BIT   = 6;
  localparam int LVD_GRP   = 1;
  localparam int GLOBAL_BIT = 0;

  localparam logic [PSC_SRC_W-1:0] PSC_SYS      = 2'h0;
  localparam logic [PSC_SRC_W-1:0] PSC_SYS_DIV4 = 2'h1;
  localparam logic [1:0]           DIV4_LAST    = 2'h3;
  localparam logic [CNT_W:0]       TB_BASE      = 16'h0100;
  localparam logic [CNT_W:0]       TB_ONE       = 16'h0001;
  localparam logic [DATA_W-1:0]    RD_NONE      = 8'h00;

  // candidate order is service priority, highest first
  localparam logic [VEC_W-1:0] VEC_TABLE [NUM_CAND] = '{
    8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h28, 8'h2c, 8'h30};
endpackage

// ### tb/core_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_model
  import irq_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             irq_req,
  input  wire logic [VEC_W-1:0] irq_vector,
  input  wire logic [2:0]       ack_delay,
  output var  logic             irq_ack,
  output var  logic             return_from_interrupt,
  output var  logic             busy,
  output var  logic [VEC_W-1:0] taken_vector,
  output var  logic [7:0]       taken_count
);
  logic [4:0] wait_cnt;

  // takes a request after a variable wait, runs a fixed-length handler, then returns
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_ack <= 1'b0;
      return_from_interrupt <= 1'b0;
      busy <= 1'b0;
      taken_vector <= 8'h00;
      taken_count <= 8'h00;
      wait_cnt <= 5'h00;
    end else begin
      irq_ack <= 1'b0;
      return_from_interrupt <= 1'b0;
      if (busy) begin
        wait_cnt <= wait_cnt + 5'h01;
        if (wait_cnt == 5'h1f) begin
          busy <= 1'b0;
          return_from_interrupt <= 1'b1;
        end
      end else if (irq_req) begin
        wait_cnt <= wait_cnt + 5'h01;
        if (wait_cnt >= {2'h0, ack_delay}) begin
          irq_ack <= 1'b1;
          busy <= 1'b1;
          wait_cnt <= 5'h00;
          taken_vector <= irq_vector;
          taken_count <= taken_count + 8'h01;
        end
      end else begin
        wait_cnt <= 5'h00;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import irq_pkg::*;
();
  localparam int TOL = 40;
  logic                                clk_sys = 1'b0;
  logic                                reset = 1'b1;
  logic [ADDR_W-1:0]                   reg_addr = 4'h0;
  logic [DATA_W-1:0]                   reg_wdata = 8'h00;
  logic                                reg_write = 1'b0;
  logic                                reg_read = 1'b0;
  logic [DATA_W-1:0]                   reg_rdata;
  logic                                conv_end = 1'b0;
  logic [NUM_TM-1:0]                   tm_match_a = '0;
  logic [NUM_TM-1:0]                   tm_match_p = '0;
  logic [SER_EVT_W-1:0]                serial_event = '0;
  logic [NUM_UART-1:0][UART_EVT_W-1:0] uart_event = '0;
  logic                                low_supply_detect = 1'b0;
  logic                                sub_clock = 1'b0;
  logic                                stack_full = 1'b0;
  logic                                irq_ack;
  logic                                return_from_interrupt;
  logic                                irq_req;
  logic [VEC_W-1:0]                    irq_vector;
  logic                                wake;
  logic                                busy;
  logic [VEC_W-1:0]                    taken_vector;
  logic [7:0]                          taken_count;
  logic [7:0]                          seen_count = 8'h00;
  logic [2:0]                          ack_delay = 3'h0;
  int                                  fail_count = 0;
  int                                  samples_checked = 0;
  int                                  cycles = 0;
  int                                  wake_count = 0;
  int                                  seed = 20;
  int                                  tb_unit [5] = '{0, 0, 1, 1, 1};
  int                                  tb_sel [5] = '{0, 0, 1, 2, 3};
  int                                  tb_code [5] = '{0, 7, 0, 1, 0};

  irq_sources_time_base u_dut (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .conv_end(conv_end),
    .tm_match_a(tm_match_a), .tm_match_p(tm_match_p), .serial_event(serial_event),
    .uart_event(uart_event), .low_supply_detect(low_supply_detect), .sub_clock(sub_clock),
    .stack_full(stack_full), .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt),
    .irq_req(irq_req), .irq_vector(irq_vector), .wake(wake));
  core_model u_core (
    .clk_sys(clk_sys), .reset(reset), .irq_req(irq_req), .irq_vector(irq_vector),
    .ack_delay(ack_delay), .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt),
    .busy(busy), .taken_vector(taken_vector), .taken_count(taken_count));

  always #10 clk_sys = ~clk_sys;
  // low-speed clock, phase unrelated to the system clock
  always #163 sub_clock = ~sub_clock;
  always @(negedge clk_sys) begin
    if (wake === 1'b1) begin
      wake_count++;
    end
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      report_and_stop();
    end
  end

  function automatic int period_cycles(input int sel, input int code);
    int tick;
    tick = (sel == 0) ? 20 : (sel == 1) ? 80 : 326;
    return ((1 << (8 + code)) * tick) / 20;
  endfunction

  task automatic report_and_stop();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    check(reg_rdata & m, exp);
  endtask

  // one-cycle event pulse; also picks a fresh response delay for the core
  task automatic pulse(input int kind, input int idx);
    @(posedge clk_sys);
    ack_delay <= 3'($random(seed));
    case (kind)
      0: conv_end <= 1'b1;
      1: tm_match_a[idx] <= 1'b1;
      2: tm_match_p[idx] <= 1'b1;
      3: serial_event[idx] <= 1'b1;
      default: uart_event[idx / 6][idx % 6] <= 1'b1;
    endcase
    @(posedge clk_sys);
    conv_end <= 1'b0;
    tm_match_a <= '0;
    tm_match_p <= '0;
    serial_event <= '0;
    uart_event <= '0;
  endtask

  task automatic take(input logic [VEC_W-1:0] vec);
    int n;
    n = 0;
    while (taken_count === seen_count && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    check(taken_count, seen_count + 8'h01);
    seen_count = taken_count;
    check(taken_vector, vec);
    rd_chk(REG_GLOBAL, 8'h00, 8'h01);
  endtask

  task automatic done_svc();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (2) @(posedge clk_sys);
    rd_chk(REG_GLOBAL, 8'h01, 8'h01);
  endtask

  task automatic no_req();
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    check({7'h00, irq_req}, 8'h00);
  endtask

  initial begin
    int w;
    int b;
    logic [7:0] d;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    for (int a = 0; a < 16; a++) begin
      rd_chk(4'(a), 8'h00, 8'hff);
    end
    for (int j = 0; j < 16; j++) begin
      d = 8'($random(seed));
      if (j % 4 > 1) begin
        d[7] = 1'b0;
      end
      wr(4'(j % 4), d);
      rd_chk(4'(j % 4), d & ((j % 4 > 1) ? 8'h87 : 8'h03), 8'hff);
    end
    wr(REG_GLOBAL, 8'h01);
    for (int k = 0; k < 5; k++) begin
      b = tb_unit[k] ? SRC_TBB : SRC_TBA;
      wr(REG_PSC_A + 4'(tb_unit[k]), 8'(tb_sel[k]));
      wr(REG_TB_A + 4'(tb_unit[k]), 8'h80 | 8'(tb_code[k]));
      rd_chk(REG_TB_A + 4'(tb_unit[k]), 8'h80 | 8'(tb_code[k]), 8'hff);
      repeat (period_cycles(tb_sel[k], tb_code[k]) - TOL) @(posedge clk_sys);
      rd_chk(REG_SRC_FLG, 8'h00, 8'(1 << b));
      repeat (2 * TOL) @(posedge clk_sys);
      rd_chk(REG_SRC_FLG, 8'(1 << b), 8'(1 << b));
      wr(REG_SRC_EN, 8'(1 << b));
      take(tb_unit[k] ? 8'h20 : 8'h1c);
      rd_chk(REG_SRC_FLG, 8'h00, 8'(1 << b));
      done_svc();
      wr(REG_TB_A + 4'(tb_unit[k]), 8'h00);
      wr(REG_SRC_EN, 8'h00);
    end
    w = wake_count;
    pulse(3, 2);
    no_req();
    check(8'(wake_count - w), 8'h01);
    rd_chk(REG_SRC_FLG, 8'h08, 8'h08);
    wr(REG_SRC_EN, 8'h39);
    take(8'h28);
    done_svc();
    @(posedge clk_sys);
    stack_full <= 1'b1;
    pulse(0, 0);
    no_req();
    @(posedge clk_sys);
    stack_full <= 1'b0;
    take(8'h18);
    rd_chk(REG_SRC_FLG, 8'h00, 8'h01);
    done_svc();
    for (int k = 0; k < 16; k++) begin
      b = (k < 4) ? SRC_SER : (k < 10) ? SRC_UART0 : SRC_UART0 + 1;
      w = wake_count;
      pulse((k < 4) ? 3 : 4, (k < 4) ? k : k - 4);
      take((k < 4) ? 8'h28 : (k < 10) ? 8'h2c : 8'h30);
      check(8'(wake_count - w), 8'h01);
      rd_chk(REG_SRC_FLG, 8'h00, 8'(1 << b));
      done_svc();
    end
    for (int i = 0; i < 6; i++) begin
      wr(REG_TML_EN, 8'(1 << i));
      wr(REG_GRP_EN, 8'h00);
      pulse(1 + i % 2, i / 2);
      no_req();
      rd_chk(REG_GRP_FLG, 8'(1 << (i / 2)), 8'h07);
      wr(REG_GRP_EN, 8'(1 << (i / 2)));
      take(8'h0c + 8'(4 * (i / 2)));
      rd_chk(REG_TML_FLG, 8'(1 << i), 8'h7f);
      rd_chk(REG_GRP_FLG, 8'h00, 8'h07);
      done_svc();
      wr(REG_TML_FLG, 8'(1 << i));
      rd_chk(REG_TML_FLG, 8'h00, 8'h7f);
    end
    wr(REG_TML_EN, 8'h40);
    wr(REG_GRP_EN, 8'h02);
    @(posedge clk_sys);
    low_supply_detect <= 1'b1;
    take(8'h10);
    rd_chk(REG_TML_FLG, 8'h40, 8'h40);
    done_svc();
    @(posedge clk_sys);
    low_supply_detect <= 1'b0;
    repeat (6) @(posedge clk_sys);
    wr(REG_TML_FLG, 8'h40);
    rd_chk(REG_TML_FLG, 8'h00, 8'h40);
    report_and_stop();
  end
endmodule
`default_nettype wire
